// [hw/mpu_permission_attribute_check.sv]
// Permission and attribute check of the memory protection unit.
// Assumes region address compares arrive as match and subregion bits,
// all from logic on core_clk_in.
`timescale 1ns/10ps

module mpu_permission_attribute_check #(
  parameter int NUM_REGIONS = mpu_check_pkg::REGIONS,
  parameter int IDX_W       = mpu_check_pkg::REG_IDX_W
) (
  input  wire logic                             core_clk_in,
  input  wire logic                             rstn_in,
  input  wire logic                             mpu_enable_in,
  input  wire logic                             background_enable_in,
  input  wire logic                             access_valid_in,
  input  wire logic [31:0]                      access_addr_in,
  input  wire logic                             access_write_in,
  input  wire logic                             access_fetch_in,
  input  wire logic                             access_priv_in,
  input  wire logic [NUM_REGIONS-1:0]           region_match_in,
  input  wire logic [NUM_REGIONS-1:0]           region_sub_off_in,
  input  wire logic [NUM_REGIONS-1:0][mpu_check_pkg::ATTR_W-1:0]
                                                region_attribute_size_reg_in,
  input  wire logic [mpu_check_pkg::STAT_W-1:0] status_clear_in,
  output logic                                  perm_fault_out,
  output logic                                  memmanage_req_out,
  output logic [mpu_check_pkg::STAT_W-1:0]      memmanage_fault_status_reg_out,
  output logic [31:0]                           fault_addr_out,
  output logic                                  region_hit_out,
  output logic [IDX_W-1:0]                      region_index_out,
  output mpu_check_pkg::mem_kind_type           mem_kind_out,
  output logic                                  shareable_out,
  output mpu_check_pkg::cache_policy_type       inner_cache_policy_out,
  output mpu_check_pkg::cache_policy_type       outer_cache_policy_out
);
  import mpu_check_pkg::*;

  // ==========================================================================
  // Region selection
  logic [NUM_REGIONS-1:0] covers;
  logic                   any_hit;
  logic [IDX_W-1:0]       win_idx;
  logic [ATTR_W-1:0]      win_attr;

  // A region covers only when enabled and the subregion is not switched off
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGIONS; gi++)
    begin : g_cover
      assign covers[gi] = region_attribute_size_reg_in[gi][EN_BIT]
                          & region_match_in[gi]
                          & ~region_sub_off_in[gi];                  // [R20]
    end
  endgenerate

  // Ascending scan so the last, highest-numbered match overrides the rest
  always_comb
  begin
    any_hit  = 1'b0;
    win_idx  = '0;
    win_attr = '0;
    for (int i = 0; i < NUM_REGIONS; i++)
    begin
      if (covers[i])
      begin
        any_hit  = 1'b1;
        win_idx  = IDX_W'(i);                                        // [R19]
        win_attr = region_attribute_size_reg_in[i];                  // [R19]
      end
    end
  end

  // ==========================================================================
  // Attribute fields of the winning region
  logic [2:0] access_permission_field;
  logic       execute_never_flag;
  logic [2:0] memory_type_extension_field;

  assign access_permission_field     = win_attr[PERM_LSB+:3];  // [R1]
  assign execute_never_flag          = win_attr[NOEXEC_BIT];   // [R1]
  assign memory_type_extension_field = win_attr[MTYPE_LSB+:3]; // [R1]

  // ==========================================================================
  // Memory type decode, informational only
  attr_decode_if dec_bus ();

  assign dec_bus.ext     = memory_type_extension_field;              // [R1]
  assign dec_bus.shr     = win_attr[S_BIT];
  assign dec_bus.cac     = win_attr[C_BIT];
  assign dec_bus.buf_bit = win_attr[B_BIT];

  mem_type_decoder u_decoder (
    .dec (dec_bus.decoder)
  );

  // ==========================================================================
  // Permission decision, purely combinational
  logic allowed;
  logic fault_now;

  // No covering region: only privileged code may use the background map
  always_comb
  begin
    allowed = 1'b1;
    if (mpu_enable_in)
    begin
      if (any_hit)
      begin
        allowed = perm_allows(access_permission_field, access_priv_in,
                              access_write_in);                      // [R2]
        if (access_fetch_in && execute_never_flag)
        begin
          allowed = 1'b0;                                            // [R1]
        end
      end
      else
      begin
        allowed = background_enable_in & access_priv_in;             // [R20]
      end
    end
  end

  assign fault_now         = access_valid_in & ~allowed;             // [R2]
  assign perm_fault_out    = fault_now;                              // [R21]
  assign memmanage_req_out = fault_now;                              // [R17]

  // ==========================================================================
  // Fault status and address capture
  logic [STAT_W-1:0] stat_q;
  logic [STAT_W-1:0] stat_d;
  logic [31:0]       faddr_q;
  logic [31:0]       faddr_d;

  // Clear first, then set, so a fault in the clearing cycle survives
  always_comb
  begin
    stat_d  = stat_q & ~status_clear_in;
    faddr_d = faddr_q;
    if (fault_now)
    begin
      if (access_fetch_in)
      begin
        stat_d[STAT_IACC_BIT] = 1'b1;                                // [R18]
      end
      else
      begin
        stat_d[STAT_DACC_BIT] = 1'b1;                                // [R18]
        // Fetch addresses may be speculative, so none is kept
        stat_d[STAT_AVLD_BIT] = 1'b1;                                // [R18]
        faddr_d               = access_addr_in;                      // [R18]
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stat_q  <= STAT_RESET;
      faddr_q <= ADDR_RESET;
    end
    else
    begin
      stat_q  <= stat_d;
      faddr_q <= faddr_d;
    end
  end

  assign memmanage_fault_status_reg_out = stat_q;
  assign fault_addr_out                 = faddr_q;

  // ==========================================================================
  // Registered attribute report of the last valid access
  logic             hit_q;
  logic             hit_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  mem_kind_type     kind_q;
  mem_kind_type     kind_d;
  logic             shr_q;
  logic             shr_d;
  cache_policy_type inner_q;
  cache_policy_type inner_d;
  cache_policy_type outer_q;
  cache_policy_type outer_d;

  // Exported for the system only; nothing here acts on them
  always_comb
  begin
    hit_d   = hit_q;
    idx_d   = idx_q;
    kind_d  = kind_q;
    shr_d   = shr_q;
    inner_d = inner_q;
    outer_d = outer_q;
    if (access_valid_in)
    begin
      hit_d   = any_hit;
      idx_d   = win_idx;
      kind_d  = dec_bus.kind;                                        // [R15]
      shr_d   = dec_bus.shareable;                                   // [R15]
      inner_d = dec_bus.inner_pol;                                   // [R15]
      outer_d = dec_bus.outer_pol;                                   // [R15]
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      hit_q   <= 1'b0;
      idx_q   <= '0;
      kind_q  <= MT_STRONG;
      shr_q   <= 1'b0;
      inner_q <= POL_NONCACHE;
      outer_q <= POL_NONCACHE;
    end
    else
    begin
      hit_q   <= hit_d;
      idx_q   <= idx_d;
      kind_q  <= kind_d;
      shr_q   <= shr_d;
      inner_q <= inner_d;
      outer_q <= outer_d;
    end
  end

  assign region_hit_out         = hit_q;
  assign region_index_out       = idx_q;
  assign mem_kind_out           = kind_q;
  assign shareable_out          = shr_q;
  assign inner_cache_policy_out = inner_q;
  assign outer_cache_policy_out = outer_q;

endmodule

// [hw/mpu_check_pkg.sv]
// Constants and types of the permission and attribute check.
// Assumes region attribute words are laid out as the fields below.
//
// Function
// R1: Access rights come from the region's attribute fields.
// R2: Fault accesses the permission forbids at current privilege.
// R3: Permission 000 denies all accesses.
// R4: Permission 001: privileged read/write only.
// R5: Permission 010: unprivileged writes fault.
// R6: Permission 011 is full access; 100 is reserved.
// R7: Permission 101: privileged reads only.
// R8: Permission 110 and 111: reads only, both levels.
// R9: Extension 000, C clear: B picks ordered or device, shareable.
// R10: Extension 000, C set: normal write-through, S selects.
// R11: Extension 001: CB 00 uncached, 11 write-back, else reserved.
// R12: Extension 010: CB 00 nonshared device, else reserved.
// R13: Extension top bit: normal, low bits outer, CB inner policy.
// R14: Policy 00 none, 01 WB alloc, 10 WT, 11 WB no alloc.
// R15: Shareability and cache policy are reported only.
// R16: Software programs recommended S, C, B with extension 000.
// R17: A violation raises a memory management fault.
// R18: Record the fault cause in the fault status register.
// R19: Highest-numbered enabled region wins on overlap.
// R20: Disabled subregion with no other region faults; code passes privileged access there when background_enable_in is set.
// R21: One fault output, same cycle as the decision.
package mpu_check_pkg;

  // ==========================================================================
  // Region attribute word layout
  localparam int ATTR_W       = 32;
  localparam int NOEXEC_BIT   = 28;
  localparam int PERM_LSB     = 24;
  localparam int MTYPE_LSB    = 19;
  localparam int S_BIT        = 18;
  localparam int C_BIT        = 17;
  localparam int B_BIT        = 16;
  localparam int EN_BIT       = 0;

  // ==========================================================================
  // Fault status register layout and reset values
  localparam int               STAT_W        = 8;
  localparam int               STAT_IACC_BIT = 0;
  localparam int               STAT_DACC_BIT = 1;
  localparam int               STAT_AVLD_BIT = 7;
  localparam logic [STAT_W-1:0] STAT_RESET   = 8'h00;
  localparam logic [31:0]       ADDR_RESET   = 32'h0000_0000;
  localparam int               REGIONS       = 8;
  localparam int               REG_IDX_W     = 3;

  // ==========================================================================
  // Permission codes
  localparam logic [2:0] PERM_NONE     = 3'h0;
  localparam logic [2:0] PERM_PRIV_RW  = 3'h1;
  localparam logic [2:0] PERM_USER_RO  = 3'h2;
  localparam logic [2:0] PERM_FULL     = 3'h3;
  localparam logic [2:0] PERM_RSVD     = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO  = 3'h5;
  localparam logic [2:0] PERM_ALL_RO_A = 3'h6;
  localparam logic [2:0] PERM_ALL_RO_B = 3'h7;

  // ==========================================================================
  // Decoded attribute types
  typedef enum logic [1:0] {
    MT_STRONG,
    MT_DEVICE,
    MT_NORMAL,
    MT_RESERVED
  } mem_kind_type;

  // Order matches the two-bit policy code
  typedef enum logic [1:0] {
    POL_NONCACHE,
    POL_WB_RWA,
    POL_WT_NWA,
    POL_WB_NWA
  } cache_policy_type;

  // ==========================================================================
  // Permission table; the reserved code is treated as no access
  function automatic logic perm_allows(input logic [2:0] pm,
                                       input logic       priv,
                                       input logic       write);
    logic ok;
    ok = 1'b0;
    case (pm)
      PERM_NONE:     ok = 1'b0;              // [R3]
      PERM_PRIV_RW:  ok = priv;              // [R4]
      PERM_USER_RO:  ok = priv | ~write;     // [R5]
      PERM_FULL:     ok = 1'b1;              // [R6]
      PERM_RSVD:     ok = 1'b0;              // [R6]
      PERM_PRIV_RO:  ok = priv & ~write;     // [R7]
      PERM_ALL_RO_A: ok = ~write;            // [R8]
      PERM_ALL_RO_B: ok = ~write;            // [R8]
      default:       ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

// [hw/attr_decode_if.sv]
// Carrier between the check block and its memory type decoder.
// Assumes both ends run combinationally within one clock cycle.
`timescale 1ns/10ps

interface attr_decode_if;
  import mpu_check_pkg::*;

  logic [2:0]       ext;
  logic             shr;
  logic             cac;
  logic             buf_bit;
  mem_kind_type     kind;
  logic             shareable;
  cache_policy_type inner_pol;
  cache_policy_type outer_pol;

  // ==========================================================================
  // Ports
  modport decoder (
    input  ext,
    input  shr,
    input  cac,
    input  buf_bit,
    output kind,
    output shareable,
    output inner_pol,
    output outer_pol
  );

  modport user (
    output ext,
    output shr,
    output cac,
    output buf_bit,
    input  kind,
    input  shareable,
    input  inner_pol,
    input  outer_pol
  );
endinterface

// [hw/mem_type_decoder.sv]
// Decodes extension, S, C and B bits into memory kind and policies.
// Assumes the caller feeds the winning region's fields.
`timescale 1ns/10ps

module mem_type_decoder (
  attr_decode_if.decoder dec
);
  import mpu_check_pkg::*;

  // ==========================================================================
  // Memory type table; results only inform the system, nothing is cached
  always_comb
  begin
    dec.kind      = MT_RESERVED;
    dec.shareable = 1'b0;
    dec.inner_pol = POL_NONCACHE;
    dec.outer_pol = POL_NONCACHE;
    if (dec.ext[2])
    begin
      dec.kind      = MT_NORMAL;                                     // [R13]
      dec.shareable = dec.shr;                                       // [R13]
      dec.outer_pol = cache_policy_type'(dec.ext[1:0]);              // [R14]
      dec.inner_pol = cache_policy_type'({dec.cac, dec.buf_bit});    // [R14]
    end
    else
    begin
      case (dec.ext[1:0])
        2'h0:
        begin
          if (!dec.cac)
          begin
            // Shareable bit ignored for ordered and device memory
            dec.kind      = dec.buf_bit ? MT_DEVICE : MT_STRONG;     // [R9]
            dec.shareable = 1'b1;                                    // [R9]
          end
          else
          begin
            dec.kind      = MT_NORMAL;                               // [R10]
            dec.shareable = dec.shr;                                 // [R10]
            dec.inner_pol = POL_WT_NWA;                              // [R10]
            dec.outer_pol = POL_WT_NWA;
          end
        end
        2'h1:
        begin
          if (dec.cac == dec.buf_bit)
          begin
            dec.kind      = MT_NORMAL;                               // [R11]
            dec.shareable = dec.shr;
            dec.inner_pol = dec.cac ? POL_WB_RWA : POL_NONCACHE;     // [R11]
            dec.outer_pol = dec.cac ? POL_WB_RWA : POL_NONCACHE;
          end
        end
        2'h2:
        begin
          if (!dec.cac && !dec.buf_bit)
          begin
            dec.kind      = MT_DEVICE;                               // [R12]
            dec.shareable = 1'b0;                                    // [R12]
          end
        end
        default:
        begin
          dec.kind = MT_RESERVED;
        end
      endcase
    end
  end

endmodule

// [sim/perm_check_monitor.sv]
// Concurrent checks on the permission and attribute check.
// Sees only top ports; bound in at the file foot.
`timescale 1ns/10ps

module perm_check_monitor
  import mpu_check_pkg::*;
#(
  parameter int NUM_REGIONS = REGIONS,
  parameter int IDX_W       = REG_IDX_W
) (
  input wire logic                   core_clk_in,
  input wire logic                   rstn_in,
  input wire logic                   mpu_enable_in,
  input wire logic                   background_enable_in,
  input wire logic                   access_valid_in,
  input wire logic [31:0]            access_addr_in,
  input wire logic                   access_write_in,
  input wire logic                   access_fetch_in,
  input wire logic                   access_priv_in,
  input wire logic [NUM_REGIONS-1:0] region_match_in,
  input wire logic [NUM_REGIONS-1:0] region_sub_off_in,
  input wire logic [NUM_REGIONS-1:0][ATTR_W-1:0]
                                     region_attribute_size_reg_in,
  input wire logic [STAT_W-1:0]      status_clear_in,
  input wire logic                   perm_fault_out,
  input wire logic                   memmanage_req_out,
  input wire logic [STAT_W-1:0]      memmanage_fault_status_reg_out,
  input wire logic [31:0]            fault_addr_out,
  input wire logic                   region_hit_out,
  input wire logic [IDX_W-1:0]       region_index_out
);
  // Allowed bits per permission code, index {code, priv, write}
  localparam logic [31:0] ALLOW = 32'h5540_FDC0;

  logic             hit;
  logic [IDX_W-1:0] win;
  logic [2:0]       pm;
  logic             nx;
  logic             ok;

  // ==========================================================================
  // Winning region: highest number wins, so later loop passes overwrite
  always_comb
  begin
    hit = 1'b0;
    win = '0;
    for (int i = 0; i < NUM_REGIONS; i++)
      if (region_match_in[i] && !region_sub_off_in[i] &&
          region_attribute_size_reg_in[i][EN_BIT])
      begin
        hit = 1'b1;
        win = IDX_W'(i);
      end
    pm = region_attribute_size_reg_in[win][PERM_LSB+:3];
    nx = region_attribute_size_reg_in[win][NOEXEC_BIT];
    ok = ALLOW[{pm, access_priv_in, access_write_in}];
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // ==========================================================================
  // Assertions
  req_mirror_a:
    assert property (memmanage_req_out == perm_fault_out)
    else $error("exception request differs from fault");
  idle_quiet_a:
    assert property (!access_valid_in |-> !perm_fault_out)
    else $error("fault without an access");
  mpu_off_a:
    assert property (!mpu_enable_in |-> !perm_fault_out)
    else $error("fault while protection is off");
  perm_table_a:
    assert property (access_valid_in && mpu_enable_in && hit &&
      !(access_fetch_in && nx) |-> perm_fault_out == !ok)
    else $error("fault disagrees with permission code");
  fetch_never_a:
    assert property (access_valid_in && mpu_enable_in && hit &&
      access_fetch_in && nx |-> perm_fault_out)
    else $error("fetch from no-execute region allowed");
  no_region_a:
    assert property (access_valid_in && mpu_enable_in && !hit |->
      perm_fault_out == !(background_enable_in && access_priv_in))
    else $error("uncovered access handled wrongly");
  data_cause_a:
    assert property (perm_fault_out && !access_fetch_in |=>
      memmanage_fault_status_reg_out[STAT_DACC_BIT] &&
      memmanage_fault_status_reg_out[STAT_AVLD_BIT] &&
      fault_addr_out == $past(access_addr_in))
    else $error("data fault cause not recorded");
  fetch_cause_a:
    assert property (perm_fault_out && access_fetch_in |=>
      memmanage_fault_status_reg_out[STAT_IACC_BIT])
    else $error("fetch fault cause not recorded");
  clear_bit_a:
    assert property (status_clear_in[STAT_DACC_BIT] &&
      !(perm_fault_out && !access_fetch_in) |=>
      !memmanage_fault_status_reg_out[STAT_DACC_BIT])
    else $error("status bit survived its clear");
  winner_a:
    assert property (access_valid_in |=> region_hit_out == $past(hit) &&
      (!$past(hit) || region_index_out == $past(win)))
    else $error("wrong winning region reported");

  cover property (perm_fault_out && access_fetch_in);
  cover property (access_valid_in && hit && !perm_fault_out);
  cover property (status_clear_in[1] && memmanage_fault_status_reg_out[1]);
endmodule

bind mpu_permission_attribute_check perm_check_monitor #(
  .NUM_REGIONS(NUM_REGIONS), .IDX_W(IDX_W)) mon_u (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .mpu_enable_in(mpu_enable_in),
  .background_enable_in(background_enable_in),
  .access_valid_in(access_valid_in), .access_addr_in(access_addr_in),
  .access_write_in(access_write_in), .access_fetch_in(access_fetch_in),
  .access_priv_in(access_priv_in), .region_match_in(region_match_in),
  .region_sub_off_in(region_sub_off_in),
  .region_attribute_size_reg_in(region_attribute_size_reg_in),
  .status_clear_in(status_clear_in), .perm_fault_out(perm_fault_out),
  .memmanage_req_out(memmanage_req_out),
  .memmanage_fault_status_reg_out(memmanage_fault_status_reg_out),
  .fault_addr_out(fault_addr_out), .region_hit_out(region_hit_out),
  .region_index_out(region_index_out));

// [sim/core_access_model.sv]
// Model of the core load/store and fetch path presenting accesses.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/10ps

module core_access_model (
  output logic        valid_out,
  output logic [31:0] addr_out,
  output logic        write_out,
  output logic        fetch_out,
  output logic        priv_out
);
  // ==========================================================================
  // Power-up: no access presented
  initial
  begin
    valid_out = 1'b0;
    addr_out  = 32'h0;
    write_out = 1'b0;
    fetch_out = 1'b0;
    priv_out  = 1'b0;
  end

  // One access, held for the whole cycle; this path has no handshake
  task automatic issue(input logic w, f, p, input logic [31:0] a);
    valid_out = 1'b1;
    write_out = w;
    fetch_out = f;
    priv_out  = p;
    addr_out  = a;
  endtask

  // Released qualifiers flip, so a stale value never passes for a live one
  task automatic rest();
    valid_out = 1'b0;
    addr_out  = ~addr_out;
    write_out = ~write_out;
    fetch_out = ~fetch_out;
    priv_out  = ~priv_out;
  endtask

  // Software setup {S,C,B}: flash, internal RAM, external RAM, peripherals
  function automatic logic [2:0] sw_scb(input int kind);
    case (kind)
      0:       return 3'b010;
      1:       return 3'b110;
      2:       return 3'b111;
      default: return 3'b101;
    endcase
  endfunction
endmodule

// [sim/mpu_permission_attribute_check_tb_top.sv]
// Self-checking bench for the permission and attribute check.
// Assumes the bound monitor and the core access model.
`timescale 1ns/10ps

module mpu_permission_attribute_check_tb_top;
  import mpu_check_pkg::*;

  localparam logic [31:0] ALLOW = 32'h5540_FDC0;

  logic                  core_clk_in;
  logic                  rstn_in;
  logic                  en;
  logic                  bg;
  logic                  valid;
  logic [31:0]           addr;
  logic                  wr;
  logic                  fe;
  logic                  pr;
  logic [7:0]            match;
  logic [7:0]            sub;
  logic [7:0][31:0]      attr;
  logic [7:0]            clr;
  logic                  fault;
  logic                  req;
  logic [7:0]            stat;
  logic [31:0]           faddr;
  logic                  hit;
  logic [2:0]            idx;
  mem_kind_type          kind;
  logic                  shr;
  cache_policy_type      inpol;
  cache_policy_type      outpol;
  logic [8:0]            e;
  int                    bad_count;
  int                    total_checks;

  core_access_model cpu_u (.valid_out(valid), .addr_out(addr),
    .write_out(wr), .fetch_out(fe), .priv_out(pr));

  mpu_permission_attribute_check dut_u (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .mpu_enable_in(en), .background_enable_in(bg),
    .access_valid_in(valid), .access_addr_in(addr),
    .access_write_in(wr), .access_fetch_in(fe), .access_priv_in(pr),
    .region_match_in(match), .region_sub_off_in(sub),
    .region_attribute_size_reg_in(attr), .status_clear_in(clr),
    .perm_fault_out(fault), .memmanage_req_out(req),
    .memmanage_fault_status_reg_out(stat), .fault_addr_out(faddr),
    .region_hit_out(hit), .region_index_out(idx), .mem_kind_out(kind),
    .shareable_out(shr), .inner_cache_policy_out(inpol),
    .outer_cache_policy_out(outpol));

  // ==========================================================================
  // Clock and compare helpers
  initial
  begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({31'h0, got}, {31'h0, exp});
  endtask

  // Enabled region at index i, covering the address
  task automatic region(input int i, input logic [2:0] pm, t, scb,
                        input logic nx);
    attr[i] = {3'h0, nx, 1'b0, pm, 2'h0, t, scb, 15'h0, 1'b1};
    match[i] = 1'b1;
  endtask

  // One access; cl set clears the status after it, cl low keeps sticky bits for inspection
  task automatic access(input logic w, f, p, input logic [31:0] a,
                        input logic ef, input logic cl);
    @(negedge core_clk_in);
    clr = 8'h00;
    cpu_u.issue(w, f, p, a);
    #2;
    chk_bit(fault, ef);
    chk_bit(req, ef);
    @(negedge core_clk_in);
    cpu_u.rest();
    chk_vec(32'(stat), ef ? (f ? 32'h01 : 32'h82) : 32'h0);
    if (ef && !f) chk_vec(faddr, a);
    clr = cl ? 8'hFF : 8'h00;
  endtask

  // Expected {check policy, check share, kind, share, inner, outer}
  function automatic logic [8:0] exp_attr(input logic [2:0] t, scb);
    logic s, c, b;
    {s, c, b} = scb;
    if (t[2]) return {2'b11, 2'd2, s, c, b, t[1:0]};
    if (t == 3'h0 && !c) return {2'b01, b ? 2'd1 : 2'd0, 5'h10};
    if (t == 3'h0) return {2'b11, 2'd2, s, 4'hA};
    if (t == 3'h1 && c == b) return {2'b11, 2'd2, s, c ? 4'h5 : 4'h0};
    if (t == 3'h2 && !c && !b) return {2'b01, 2'd1, 5'h00};
    return {2'b00, 2'd3, 5'h00};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is a few hundred cycles; the margin here is generous
  initial
  begin
    #200_000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    {bad_count, total_checks} = '0;
    {rstn_in, en, bg, match, sub, attr, clr} = '0;
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in);
    {rstn_in, en, bg} = 3'b111;
    chk_vec({stat, faddr[7:0], 6'h0, kind}, 32'h0);
    $display("test reset done");
    region(3, 3'h0, 3'h0, 3'b010, 1'b0);
    for (int k = 0; k < 32; k++)
    begin
      attr[3][PERM_LSB+:3] = k[4:2];
      access(k[0], 1'b0, k[1], 32'h2000_0100 + k, ~ALLOW[k], 1);
    end
    $display("test permission table done");
    region(3, PERM_FULL, 3'h0, 3'b010, 1'b1);
    access(1'b0, 1'b1, 1'b1, 32'h0000_0040, 1'b1, 1);
    access(1'b0, 1'b0, 1'b0, 32'h0000_0044, 1'b0, 1);
    attr[3][NOEXEC_BIT] = 1'b0;
    access(1'b0, 1'b1, 1'b0, 32'h0000_0048, 1'b0, 1);
    $display("test execute never done");
    match = '0;
    region(2, PERM_FULL, 3'h0, cpu_u.sw_scb(0), 1'b0);
    region(5, PERM_NONE, 3'h0, cpu_u.sw_scb(1), 1'b0);
    access(1'b1, 1'b0, 1'b1, 32'h2000_0010, 1'b1, 1);
    chk_vec(32'(idx), 32'h5);
    sub[5] = 1'b1;
    access(1'b1, 1'b0, 1'b1, 32'h2000_0014, 1'b0, 1);
    chk_vec(32'(idx), 32'h2);
    sub[2] = 1'b1;
    access(1'b1, 1'b0, 1'b1, 32'h2000_0018, 1'b0, 1);
    chk_bit(hit, 1'b0);
    access(1'b0, 1'b0, 1'b0, 32'h2000_001C, 1'b1, 1);
    bg = 1'b0;
    access(1'b0, 1'b0, 1'b1, 32'h2000_0020, 1'b1, 1);
    en = 1'b0;
    access(1'b1, 1'b0, 1'b0, 32'h2000_0024, 1'b0, 1);
    {en, bg, sub, match} = {2'b11, 16'h0};
    $display("test overlap and background done");
    for (int k = 0; k < 64; k++)
    begin
      region(1, PERM_FULL, k[5:3], k[2:0], 1'b0);
      access(1'b1, 1'b0, 1'b0, 32'h3000_0000, 1'b0, 1);
      e = exp_attr(k[5:3], k[2:0]);
      chk_vec(32'(kind), 32'(e[6:5]));
      if (e[7]) chk_bit(shr, e[4]);
      if (e[8]) chk_vec(32'({inpol, outpol}), 32'(e[3:0]));
    end
    $display("test memory attributes done");
    region(1, PERM_USER_RO, 3'h0, 3'b110, 1'b0);
    access(1'b1, 1'b0, 1'b0, 32'h3000_0080, 1'b1, 0);
    @(negedge core_clk_in);
    clr = 8'h02;
    @(negedge core_clk_in);
    clr = 8'hFF;
    chk_vec(32'(stat), 32'h80);
    access(1'b0, 1'b0, 1'b0, 32'h3000_0084, 1'b0, 1);
    $display("test status clear done");
    finish_test();
  end
endmodule
